// File: reset_opmode_nvm_autoload.v
`timescale 1ns/1ps
`default_nettype none
`include "reset_opmode_regs.vh"

// Summary of operation
// - after power-on, wait about 5 ms, then trigger a system reset.
// - software reset command or falling edge of reset pin also cause system reset.
// - reset sets mode to Reset and restores all control registers.
// - mode code is 00 Reset, 10 Sleep, 11 Normal.
// - Reset/Sleep drain on, drivers/clock/pump off; Normal the reverse.
// - only power-on reset, display enable, system reset change mode.
// - display enable bit 2 selects Normal (1), or Sleep (0) unless mode is Reset.
// - mode changes take effect on internal clock edges.
// - Sleep keeps all user-written control values.
// - drivers stay idle until drive and bias voltages are ready.
// - after power-up wait, commands accepted in any order, no delays.
// - trim read runs after hardware reset or trim read command, never software reset.
// - busy/success flags step 00, 10, 11, then 01 when ready.
// - trim read and display enable exclude each other; conflict ignored.
module reset_opmode_nvm_autoload #(
    parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // clock, reset, enable
    input wire clock,
    input wire reset,
    input wire clockEnable,
    // reset pin, active low
    input wire resetPin_n,
    // voltage readiness from analog section
    input wire driveVoltageReady,
    input wire biasVoltageReady,
    // trim cells as read by the nonvolatile array
    input wire [7:0] trimCells,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // analog controls
    output reg [1:0] operatingModeCode,
    output reg drainEnable,
    output reg driverEnable,
    output reg clockRun,
    output reg pumpEnable,
    output reg commonDriverActive,
    output reg segmentDriverActive,
    output reg nvmBusyFlag,
    output reg nvmSuccessFlag,
    output reg [7:0] trimValue
);

    // ----------------------------------------
    // states of the trim read
    // ----------------------------------------
    localparam TRIM_IDLE = 2'h0;
    localparam TRIM_START = 2'h1;
    localparam TRIM_CHECK = 2'h2;

    reg [22:0] settleCount;
    reg settling;
    reg [2:0] displayControlField;
    reg [1:0] trimState;
    reg [15:0] trimCount;
    reg pinLast;
    reg [1:0] next_mode;

    wire apbAccess = psel && penable && !pready;
    wire apbWrite = apbAccess && pwrite;
    wire [7:0] command = pwdata[7:0];
    wire isCommand = apbWrite && (paddr == `ADDR_COMMAND);
    // hardware reset: power-on settle expiry or falling edge of the pin
    wire pinFall = pinLast && !resetPin_n;
    // the settle expiry is the last count, not the zero at reset release
    wire settleDone = settling &&
        (settleCount == SETTLE_CYCLES[22:0] - 23'h000001);
    wire hardReset = settleDone || pinFall;
    wire softReset = isCommand && (command == `CMD_SYSTEM_RESET);
    wire trimBusy = (trimState != TRIM_IDLE);
    wire wantEnable = isCommand && (command == `CMD_DISPLAY_ENABLE);
    wire wantDisable = isCommand && (command == `CMD_DISPLAY_DISABLE);
    // display enable is refused during a trim read, and the reverse
    wire takeEnable = wantEnable && !trimBusy;
    wire takeTrim = isCommand && (command == `CMD_TRIM_READ) &&
        !trimBusy && !displayControlField[`DISPLAY_ENABLE_BIT];

    function [2:0] modeOutputs;
        input [1:0] mode;
        begin
            modeOutputs = (mode == `MODE_NORMAL) ? 3'h7 : 3'h0;
        end
    endfunction

    // mode follows only reset sources and display enable bit
    always @* begin
        next_mode = operatingModeCode;
        if (hardReset || softReset) begin
            next_mode = `MODE_RESET;
        end else if (displayControlField[`DISPLAY_ENABLE_BIT]) begin
            next_mode = `MODE_NORMAL;
        end else if (operatingModeCode != `MODE_RESET) begin
            next_mode = `MODE_SLEEP;
        end
    end

    // ----------------------------------------
    // power-on settle and pin edge
    // ----------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            settleCount <= 23'h000000;
            settling <= 1'b1;
            pinLast <= 1'b1;
        end else if (clockEnable) begin
            pinLast <= resetPin_n;
            if (settling) begin
                if (settleDone) begin
                    settleCount <= 23'h000000;
                    settling <= 1'b0;
                end else begin
                    settleCount <= settleCount + 23'h000001;
                end
            end
        end
    end

    // ----------------------------------------
    // control registers, mode and trim read
    // ----------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            displayControlField <= `DISPLAY_CONTROL_RESET;
            operatingModeCode <= `MODE_RESET;
            trimState <= TRIM_IDLE;
            trimCount <= 16'h0000;
            nvmBusyFlag <= 1'b0;
            nvmSuccessFlag <= 1'b0;
            trimValue <= `TRIM_RESET;
            drainEnable <= 1'b1;
            driverEnable <= 1'b0;
            clockRun <= 1'b0;
            pumpEnable <= 1'b0;
            commonDriverActive <= 1'b0;
            segmentDriverActive <= 1'b0;
        end else if (clockEnable) begin
            operatingModeCode <= next_mode;
            {driverEnable, clockRun, pumpEnable} <= modeOutputs(next_mode);
            drainEnable <= (next_mode != `MODE_NORMAL);
            // drivers wait for both voltages, not just the mode
            commonDriverActive <= (operatingModeCode == `MODE_NORMAL) &&
                driveVoltageReady && biasVoltageReady;
            segmentDriverActive <= (operatingModeCode == `MODE_NORMAL) &&
                driveVoltageReady && biasVoltageReady;
            if (hardReset || softReset) begin
                displayControlField <= `DISPLAY_CONTROL_RESET;
            end else if (takeEnable) begin
                displayControlField[`DISPLAY_ENABLE_BIT] <= 1'b1;
            end else if (wantDisable) begin
                // sleep leaves other fields untouched
                displayControlField[`DISPLAY_ENABLE_BIT] <= 1'b0;
            end
            if (hardReset) begin
                // software reset does not start a trim read
                trimState <= TRIM_START;
                nvmBusyFlag <= 1'b0;
                nvmSuccessFlag <= 1'b0;
                trimCount <= 16'h0000;
            end else begin
                case (trimState)
                    TRIM_IDLE: begin
                        if (takeTrim) begin
                            trimState <= TRIM_START;
                            nvmSuccessFlag <= 1'b0;
                            trimCount <= 16'h0000;
                        end
                    end
                    TRIM_START: begin
                        nvmBusyFlag <= 1'b1;
                        if (trimCount == `TRIM_READ_CYCLES) begin
                            trimValue <= trimCells;
                            nvmSuccessFlag <= 1'b1;
                            trimCount <= 16'h0000;
                            trimState <= TRIM_CHECK;
                        end else begin
                            trimCount <= trimCount + 16'h0001;
                        end
                    end
                    TRIM_CHECK: begin
                        if (trimCount == `TRIM_READ_CYCLES) begin
                            nvmBusyFlag <= 1'b0;
                            trimState <= TRIM_IDLE;
                        end else begin
                            trimCount <= trimCount + 16'h0001;
                        end
                    end
                    default: begin
                        trimState <= TRIM_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // apb slave, live in every mode
    // ----------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clockEnable) begin
            pready <= apbAccess;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (apbAccess) begin
                case (paddr)
                    `ADDR_COMMAND: begin
                        prdata <= 32'h00000000;
                    end
                    `ADDR_DISPLAY: begin
                        prdata <= {29'h00000000, displayControlField};
                    end
                    `ADDR_STATUS: begin
                        prdata <= {26'h0000000, segmentDriverActive,
                            commonDriverActive, nvmBusyFlag,
                            nvmSuccessFlag, operatingModeCode};
                    end
                    `ADDR_TRIM: begin
                        prdata <= {24'h000000, trimValue};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: reset_opmode_regs.vh
`ifndef RESET_OPMODE_REGS_VH
`define RESET_OPMODE_REGS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_COMMAND 12'h000
`define ADDR_DISPLAY 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_TRIM 12'h00C

// ----------------------------------------
// command codes written to the command register
// ----------------------------------------
`define CMD_SYSTEM_RESET 8'hE2
`define CMD_DISPLAY_ENABLE 8'hAF
`define CMD_DISPLAY_DISABLE 8'hAE
`define CMD_TRIM_READ 8'hB8

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define DISPLAY_ENABLE_BIT 2
`define DISPLAY_CONTROL_RESET 3'h0
`define TRIM_RESET 8'h00

// ----------------------------------------
// operating mode codes
// ----------------------------------------
`define MODE_RESET 2'h0
`define MODE_SLEEP 2'h2
`define MODE_NORMAL 2'h3

// ----------------------------------------
// timing, clock 25 MHz
// ----------------------------------------
`define CLOCK_MHZ 25
`define SETTLE_TIME_US 5000
`define SETTLE_CYCLES (`SETTLE_TIME_US * `CLOCK_MHZ)
`define TRIM_READ_CYCLES 16'h0040

`endif

// File: reset_opmode_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_opmode_regs.vh"
// ------------------------------
// mode and reset checker
// ------------------------------
module reset_opmode_chk (
    // clock and reset
    input wire clock,
    input wire reset,
    input wire clockEnable,
    input wire resetPin_n,
    // readiness
    input wire driveVoltageReady,
    input wire biasVoltageReady,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    // status
    input wire [1:0] operatingModeCode,
    input wire drainEnable,
    input wire commonDriverActive,
    input wire segmentDriverActive,
    input wire nvmBusyFlag,
    input wire nvmSuccessFlag
);
    wire req = psel && penable && !pready && clockEnable;
    wire take = req && pwrite && paddr == `ADDR_COMMAND;
    wire [7:0] cmd = pwdata[7:0];
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    mode_code_a: assert property (operatingModeCode != 2'h1)
        else $error("mode code 01 seen");
    drain_mode_a: assert property ($stable(operatingModeCode) |->
        drainEnable == (operatingModeCode != `MODE_NORMAL))
        else $error("drain does not follow mode");
    driver_ready_a: assert property (commonDriverActive |->
        $past(driveVoltageReady && biasVoltageReady))
        else $error("drivers active before voltages ready");
    driver_pair_a: assert property (
        segmentDriverActive == commonDriverActive)
        else $error("driver enables differ");
    apb_answer_a: assert property (req |=> pready)
        else $error("no answer one cycle after access");
    apb_pulse_a: assert property (pready && clockEnable |=> !pready)
        else $error("ready longer than one cycle");
    sw_reset_a: assert property (take && cmd == `CMD_SYSTEM_RESET
        |=> operatingModeCode == `MODE_RESET)
        else $error("reset command left mode");
    sw_no_trim_a: assert property (take && cmd == `CMD_SYSTEM_RESET
        && !nvmBusyFlag |=> !nvmBusyFlag [*8])
        else $error("trim read after reset command");
    pin_reset_a: assert property ($fell(resetPin_n) |->
        ##[1:6] (nvmBusyFlag && operatingModeCode == `MODE_RESET))
        else $error("pin reset without trim read");
    flag_step_a: assert property (
        $rose(nvmSuccessFlag) |-> nvmBusyFlag)
        else $error("success rose outside busy");
    enable_a: assert property (take && cmd == `CMD_DISPLAY_ENABLE
        && !nvmBusyFlag |-> ##[1:3] operatingModeCode == `MODE_NORMAL)
        else $error("enable did not reach normal");
endmodule
bind reset_opmode_nvm_autoload reset_opmode_chk u_chk (.clock, .reset,
    .clockEnable, .resetPin_n, .driveVoltageReady, .biasVoltageReady,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .operatingModeCode, .drainEnable, .commonDriverActive,
    .segmentDriverActive, .nvmBusyFlag, .nvmSuccessFlag);
`default_nettype wire

// File: analog_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// pump ramp model: bias lags drive, both drop when pump stops
// ------------------------------
module analog_supply_model (
    input wire clock,
    input wire pumpEnable,
    output logic driveVoltageReady = 1'h0,
    output logic biasVoltageReady = 1'h0
);
    int ramp = 0;
    always @(posedge clock) begin
        ramp <= pumpEnable ? (ramp < 20 ? ramp + 1 : ramp) : 0;
        driveVoltageReady <= pumpEnable && ramp >= 10;
        biasVoltageReady <= pumpEnable && ramp >= 20;
    end
endmodule
`default_nettype wire

// File: test_reset_opmode_nvm_autoload.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_opmode_regs.vh"
module test_reset_opmode_nvm_autoload;
    logic clock = 1'h0, reset = 1'h1, resetPin_n = 1'h1, err;
    logic clockEnable = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [7:0] trimCells = 8'h5A, seq;
    wire [31:0] prdata;
    wire [1:0] operatingModeCode;
    wire pready, pslverr, drainEnable, driverEnable, clockRun, pumpEnable;
    wire commonDriverActive, segmentDriverActive, nvmBusyFlag;
    wire nvmSuccessFlag, driveVoltageReady, biasVoltageReady;
    wire [7:0] trimValue;
    int miscompares = 0, check_count = 0;
    always #20 clock = ~clock;
    reset_opmode_nvm_autoload #(.SETTLE_CYCLES(50))
        u_reset_opmode_nvm_autoload (.clock, .reset, .clockEnable,
        .resetPin_n, .driveVoltageReady, .biasVoltageReady, .trimCells,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .operatingModeCode, .drainEnable, .driverEnable,
        .clockRun, .pumpEnable, .commonDriverActive, .segmentDriverActive,
        .nvmBusyFlag, .nvmSuccessFlag, .trimValue);
    analog_supply_model u_analog_supply_model (.clock, .pumpEnable,
        .driveVoltageReady, .biasVoltageReady);
    // ------------------------------
    // apb master and compare helpers
    // ------------------------------
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1 && ++n < 40);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 40) miscompares++;
    endtask
    task automatic check(input string what, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic waitMode(input logic [1:0] m);
        for (int n = 0; n < 40 && operatingModeCode !== m; n++)
            @(posedge clock);
        check("mode", m, operatingModeCode);
    endtask
    // records each change of the flag pair until it settles at 01
    task automatic trackFlags(input logic [7:0] e);
        logic [1:0] last;
        last = {nvmBusyFlag, nvmSuccessFlag};
        seq = 8'h00;
        for (int n = 0; n < 600 && (last !== 2'h1 || seq == 8'h00); n++)
        begin
            @(posedge clock);
            if ({nvmBusyFlag, nvmSuccessFlag} !== last) begin
                last = {nvmBusyFlag, nvmSuccessFlag};
                seq = {seq[5:0], last};
            end
        end
        check("flag steps", e, seq);
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'h0;
        repeat (40) @(posedge clock);
        check("early busy", 1'h0, nvmBusyFlag);
        trackFlags(8'h2D);
        check("trim", 8'h5A, trimValue);
        xfer(1'h0, `ADDR_STATUS, 32'h0);
        check("status", 32'h04, rd);
        $display("test power_on done");
        xfer(1'h1, `ADDR_COMMAND, `CMD_DISPLAY_ENABLE);
        waitMode(`MODE_NORMAL);
        check("drivers idle", 1'h0, commonDriverActive);
        check("run", 4'h7, {drainEnable, driverEnable, clockRun,
            pumpEnable});
        for (int n = 0; n < 100 && commonDriverActive !== 1'h1; n++)
            @(posedge clock);
        check("drivers on", 1'h1, commonDriverActive);
        xfer(1'h0, `ADDR_DISPLAY, 32'h0);
        check("display", 32'h04, rd);
        xfer(1'h1, `ADDR_COMMAND, `CMD_TRIM_READ);
        repeat (4) @(posedge clock);
        check("refused trim", 1'h0, nvmBusyFlag);
        xfer(1'h0, 12'h010, 32'h0);
        check("unmapped err", 1'h1, err);
        check("unmapped data", 32'h0, rd);
        $display("test enable done");
        xfer(1'h1, `ADDR_COMMAND, `CMD_DISPLAY_DISABLE);
        waitMode(`MODE_SLEEP);
        check("sleep", 4'h8, {drainEnable, driverEnable, clockRun,
            pumpEnable});
        check("kept trim", 8'h5A, trimValue);
        xfer(1'h1, `ADDR_COMMAND, `CMD_SYSTEM_RESET);
        waitMode(`MODE_RESET);
        check("no trim", 1'h0, nvmBusyFlag);
        xfer(1'h1, `ADDR_COMMAND, `CMD_DISPLAY_ENABLE);
        waitMode(`MODE_NORMAL);
        $display("test sleep_reset done");
        // new cell contents stand for an erase followed by a program
        trimCells <= 8'hC3;
        resetPin_n <= 1'h0;
        repeat (3) @(posedge clock);
        resetPin_n <= 1'h1;
        waitMode(`MODE_RESET);
        xfer(1'h1, `ADDR_COMMAND, `CMD_DISPLAY_ENABLE);
        trackFlags(8'h0D);
        check("new trim", 8'hC3, trimValue);
        check("ignored enable", `MODE_RESET, operatingModeCode);
        $display("test pin_reset done");
        complete_run();
    end
endmodule
`default_nettype wire
